// file: logic/dcbs_bus_unit.sv
// bus interface unit end: acknowledge, read beats, write capture
`timescale 1ns/1ps
`include "dcbs_cfg.svh"
module dcbs_bus_unit import dcbs_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst_b,
  dcbs_link_if.bus_interface_unit         link,
  output      logic        memWrite,
  output      logic [31:0] memAddr,
  output      logic [63:0] memWrData,
  output      logic [7:0]  memByteEn,
  input  wire logic [63:0] memRdData,
  output      logic [31:0] memRdAddr
);
  logic       rdAct_reg;
  logic [2:0] rdLeft_reg;
  logic [31:0] rdAddr_reg;
  logic [2:0] wrLeft_reg;
  logic [31:0] wrAddr_reg;
  wire isRd = link.kind == DCBS_LINE_RD || link.kind == DCBS_WORD_RD;
  wire take = link.req;
  assign link.ack    = take;
  assign link.rdValid = rdAct_reg && link.busTick;
  assign link.rdData = memRdData;
  assign memRdAddr   = rdAddr_reg;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      rdAct_reg  <= 1'b0;
      rdLeft_reg <= 3'h0;
      rdAddr_reg <= 32'h0;
      wrLeft_reg <= 3'h0;
      wrAddr_reg <= 32'h0;
      memWrite   <= 1'b0;
      memAddr    <= 32'h0;
      memWrData  <= 64'h0;
      memByteEn  <= 8'h0;
    end
    else
    begin
      memWrite <= 1'b0;
      if (take && isRd && !link.abort)
      begin
        rdAct_reg  <= 1'b1;
        rdLeft_reg <= link.kind == DCBS_LINE_RD ? 3'(`DCBS_LINE_BEATS) : 3'h1;
        rdAddr_reg <= link.addr;
      end
      else if (link.rdValid)
      begin
        rdLeft_reg <= rdLeft_reg - 3'h1;
        rdAddr_reg <= rdAddr_reg + 32'h8;
        if (rdLeft_reg == 3'h1)
          rdAct_reg <= 1'b0;
      end
      else if (link.abort)
        rdAct_reg <= 1'b0;
      // write beats are finished regardless of abort
      if (link.wrValid)
      begin
        memWrite  <= 1'b1;
        memAddr   <= take ? link.addr : wrAddr_reg;
        memWrData <= link.wrData;
        memByteEn <= take ? link.byteEn : 8'hFF;
        wrAddr_reg <= (take ? link.addr : wrAddr_reg) + 32'h8;
      end
    end
endmodule

// file: logic/dcbs_cache_ctrl.sv
// cache controller end: request sequencing, write beats, fill transfer
`timescale 1ns/1ps
`include "dcbs_cfg.svh"
module dcbs_cache_ctrl import dcbs_pkg::*; #(
  parameter int RATIO = `DCBS_RATIO_DEFAULT
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        coreReset,
  dcbs_link_if.ctrl        link,
  input  wire logic        flushReq,
  input  wire logic [31:0] flushAddr,
  input  wire logic [63:0] flushData,
  input  wire logic        flushDataValid,
  output      logic        flushDataReady,
  output      logic        flushAccept,
  input  wire logic        opReq,
  input  wire dcbs_kind_t  opKind,
  input  wire logic [31:0] opAddr,
  input  wire logic [7:0]  opByteEn,
  input  wire logic [31:0] opWrWord,
  output      logic        opAccept,
  output      logic [31:0] rdWord,
  output      logic        rdWordValid,
  output      logic        fillWrite,
  output      logic [1:0]  fillIndex,
  output      logic [63:0] fillData,
  output      logic        busy
);
  initial if (RATIO < 1 || RATIO > 3) $error("ratio must be 1 to 3");
  typedef enum logic [1:0] {DCBS_IDLE, DCBS_FLUSH, DCBS_WRITE} dcbs_wst_t;
  // ================================================================
  // bus clock enable
  logic [1:0] divCnt_reg;
  wire        tick = (divCnt_reg == 2'(RATIO - 1));
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      divCnt_reg <= 2'h0;
    else
      divCnt_reg <= tick ? 2'h0 : divCnt_reg + 2'h1;
  assign link.busTick = tick;
  // ================================================================
  // flush queue and line data buffer
  logic [1:0]  flushCnt_reg;
  logic [31:0] flushQ_reg [`DCBS_FLUSH_QUEUE];
  wire         beatValid;
  wire [63:0]  beatData;
  logic        beatPop;
  assign flushAccept = flushReq && (flushCnt_reg < 2'(`DCBS_FLUSH_QUEUE));
  dcbs_fifo #(.WIDTH(64), .DEPTH(`DCBS_FIFO_DEPTH)) u_wrbuf (
    .clk      (clk),
    .rst_b    (rst_b),
    .inData   (flushData),
    .inValid  (flushDataValid),
    .inReady  (flushDataReady),
    .outData  (beatData),
    .outValid (beatValid),
    .outReady (beatPop)
  );
  // ================================================================
  // request sequencing
  dcbs_wst_t  wst_reg;
  logic [1:0] flushTmr_reg;
  logic [2:0] wrBeat_reg;
  logic [1:0] gap_reg;
  logic       rdBusy_reg;
  logic [2:0] rdBeat_reg;
  logic       rdLine_reg;
  logic       rdHigh_reg;
  logic [1:0] fillCnt_reg;
  logic       filling_reg;
  logic [63:0] fillBuf [`DCBS_LINE_BEATS];
  wire wrFree    = (wst_reg == DCBS_IDLE);
  wire gapOk     = (gap_reg == 2'h0);
  wire opIsRd    = opKind == DCBS_LINE_RD || opKind == DCBS_WORD_RD;
  wire opWordWr  = opReq && opKind == DCBS_WORD_WR;
  wire startWl   = tick && !coreReset && wst_reg == DCBS_FLUSH && flushTmr_reg == 2'h0 && gapOk
                   && beatValid && !opWordWr;
  // a read may still go out under core reset: it carries the abort and fetches nothing
  wire startOp   = tick && opReq && gapOk && !filling_reg &&
                   (opIsRd ? !rdBusy_reg : (!coreReset && wrFree && opKind == DCBS_WORD_WR));
  // the head entry has already left the queue once its line write runs
  wire [1:0] qSlot = flushCnt_reg - 2'(wst_reg == DCBS_WRITE) - 2'(startWl);
  assign opAccept = startOp;
  wire issue     = startWl || startOp;
  wire wlBeat    = tick && wst_reg == DCBS_WRITE;
  assign beatPop = startWl || (wlBeat && wrBeat_reg != 3'h0);
  always_comb
  begin
    link.req     = issue;
    link.kind    = startWl ? DCBS_LINE_WR : opKind;
    link.addr    = startWl ? flushQ_reg[0] : opAddr;
    link.byteEn  = (startWl || opKind == DCBS_LINE_RD) ? 8'hFF : opByteEn;
    link.wrValid = beatPop || (startOp && opKind == DCBS_WORD_WR);
    link.wrData  = beatPop ? beatData : {opWrWord, opWrWord};
    link.abort   = coreReset && (rdBusy_reg || issue || wst_reg == DCBS_WRITE);
  end
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      wst_reg      <= DCBS_IDLE;
      flushTmr_reg <= 2'h0;
      wrBeat_reg   <= 3'h0;
      gap_reg      <= 2'h0;
      flushCnt_reg <= 2'h0;
    end
    else
    begin
      flushCnt_reg <= flushCnt_reg + 2'(flushAccept) - 2'(wlBeat && wrBeat_reg == 3'h3);
      if (tick && gap_reg != 2'h0)
        gap_reg <= gap_reg - 2'h1;
      if (startOp && (opKind == DCBS_WORD_RD || opKind == DCBS_WORD_WR))
        gap_reg <= 2'(`DCBS_SINGLE_GAP - 1);
      case (wst_reg)
        DCBS_IDLE:
          if (flushCnt_reg != 2'h0 && !coreReset)
          begin
            wst_reg      <= DCBS_FLUSH;
            flushTmr_reg <= 2'(`DCBS_FLUSH_CYCLES);
          end
        DCBS_FLUSH:
          if (flushTmr_reg != 2'h0)
            flushTmr_reg <= flushTmr_reg - 2'h1;
          else if (startWl)
          begin
            wst_reg    <= DCBS_WRITE;
            wrBeat_reg <= 3'h1;
          end
        DCBS_WRITE:
          if (wlBeat)
          begin
            if (wrBeat_reg == 3'(`DCBS_LINE_BEATS - 1))
              wst_reg <= DCBS_IDLE;
            wrBeat_reg <= wrBeat_reg + 3'h1;
          end
        default:
          wst_reg <= DCBS_IDLE;
      endcase
    end
  always_ff @(posedge clk)
  begin
    if (startWl)
      flushQ_reg[0] <= flushQ_reg[1];
    if (flushAccept)
      flushQ_reg[qSlot[0]] <= flushAddr;
  end
  // ================================================================
  // read data and fill transfer
  wire rdTake = link.rdValid && rdBusy_reg;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      rdBusy_reg  <= 1'b0;
      rdLine_reg  <= 1'b0;
      rdHigh_reg  <= 1'b0;
      rdBeat_reg  <= 3'h0;
      filling_reg <= 1'b0;
      fillCnt_reg <= 2'h0;
      rdWord      <= 32'h0;
      rdWordValid <= 1'b0;
    end
    else
    begin
      rdWordValid <= 1'b0;
      if (startOp && opIsRd && !coreReset)
      begin
        rdBusy_reg <= 1'b1;
        rdLine_reg <= opKind == DCBS_LINE_RD;
        rdHigh_reg <= opAddr[2];
        rdBeat_reg <= 3'h0;
      end
      else if (coreReset)
        rdBusy_reg <= 1'b0;
      else if (rdTake)
      begin
        if (!rdLine_reg)
        begin
          rdBusy_reg  <= 1'b0;
          rdWord      <= rdHigh_reg ? link.rdData[63:32] : link.rdData[31:0];
          rdWordValid <= 1'b1;
        end
        else if (rdBeat_reg == 3'(`DCBS_LINE_BEATS - 1))
        begin
          rdBusy_reg  <= 1'b0;
          filling_reg <= 1'b1;
          fillCnt_reg <= 2'h0;
        end
        rdBeat_reg <= rdBeat_reg + 3'h1;
      end
      if (filling_reg)
      begin
        fillCnt_reg <= fillCnt_reg + 2'h1;
        if (fillCnt_reg == 2'(`DCBS_FILL_CYCLES - 1))
          filling_reg <= 1'b0;
      end
    end
  always_ff @(posedge clk)
    if (rdTake && rdLine_reg)
      fillBuf[rdBeat_reg[1:0]] <= link.rdData;
  // three fill cycles move beats 0 to 2, one beat per cycle; beat 3 of the line is never written out
  assign fillWrite = filling_reg;
  assign fillIndex = fillCnt_reg;
  assign fillData  = fillBuf[fillCnt_reg];
  assign busy      = !wrFree || rdBusy_reg || filling_reg;
endmodule

// file: logic/dcbs_cfg.svh
// constants of the data cache bus sequencer
`ifndef DCBS_CFG_SVH
`define DCBS_CFG_SVH
`define DCBS_LINE_WORDS     8
`define DCBS_LINE_BEATS     4
`define DCBS_BEAT_WIDTH     64
`define DCBS_WORD_WIDTH     32
`define DCBS_FILL_CYCLES    3
`define DCBS_FLUSH_CYCLES   2
`define DCBS_SINGLE_GAP     2
`define DCBS_FLUSH_QUEUE    2
`define DCBS_FIFO_DEPTH     32
`define DCBS_RATIO_DEFAULT  1
`endif

// file: logic/dcbs_fifo.sv
// valid/ready fifo for write beats
`timescale 1ns/1ps
`include "dcbs_cfg.svh"
module dcbs_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = `DCBS_FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output      logic             inReady,
  output      logic [WIDTH-1:0] outData,
  output      logic             outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  initial if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("depth must be a power of two");
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_reg;
  logic [AW:0]      rdPtr_reg;
  wire              push = inValid && inReady;
  wire              pop  = outValid && outReady;
  assign inReady  = (wrPtr_reg - rdPtr_reg) != (AW+1)'(DEPTH);
  assign outValid = wrPtr_reg != rdPtr_reg;
  assign outData  = mem[rdPtr_reg[AW-1:0]];
  always_ff @(posedge clk)
    if (push)
      mem[wrPtr_reg[AW-1:0]] <= inData;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end
    else
    begin
      if (push)
        wrPtr_reg <= wrPtr_reg + 1'b1;
      if (pop)
        rdPtr_reg <= rdPtr_reg + 1'b1;
    end
endmodule

// file: logic/dcbs_link_if.sv
// link between the cache controller and the bus interface unit
`timescale 1ns/1ps
interface dcbs_link_if;
  import dcbs_pkg::*;
  logic        busTick;
  logic        req;
  dcbs_kind_t  kind;
  logic [31:0] addr;
  logic [7:0]  byteEn;
  logic        abort;
  logic        ack;
  logic [63:0] wrData;
  logic        wrValid;
  logic [63:0] rdData;
  logic        rdValid;
  modport ctrl (output busTick, output req, output kind, output addr, output byteEn, output abort,
                output wrData, output wrValid, input ack, input rdData, input rdValid);
  modport bus_interface_unit  (input busTick, input req, input kind, input addr, input byteEn, input abort,
                input wrData, input wrValid, output ack, output rdData, output rdValid);
endinterface

// file: logic/dcbs_pkg.sv
// types of the data cache bus sequencer
package dcbs_pkg;
  typedef enum logic [1:0] {DCBS_LINE_RD, DCBS_WORD_RD, DCBS_LINE_WR, DCBS_WORD_WR} dcbs_kind_t;
endpackage

// file: sim/data_cache_bus_sequencer_bench.sv
// self-checking bench of the data cache bus sequencer
`timescale 1ns/1ps
module data_cache_bus_sequencer_bench;
  import dcbs_pkg::*;
  // ==========================================
  // stimulus, design and link
  logic        clk, rst_b, coreReset, flushReq, flushDataValid, opReq;
  logic [31:0] flushAddr, opAddr, opWrWord;
  logic [63:0] flushData;
  logic [7:0]  opByteEn;
  dcbs_kind_t  opKind;
  logic        flushDataReady, flushAccept, opAccept, rdWordValid, fillWrite, busy, memWrite;
  logic [31:0] rdWord, memAddr, memRdAddr;
  logic [63:0] fillData, memWrData, memRdData;
  logic [1:0]  fillIndex;
  logic [7:0]  memByteEn;
  int          wrBeats, rdBeats, fillCnt, rdWords, bad_count, checked;
  assign memRdData = {~memRdAddr, memRdAddr};
  dcbs_link_if link();
  dcbs_cache_ctrl #(.RATIO(1)) dcbs_cache_ctrl_inst (.clk(clk), .rst_b(rst_b), .coreReset(coreReset),
    .link(link), .flushReq(flushReq), .flushAddr(flushAddr), .flushData(flushData),
    .flushDataValid(flushDataValid), .flushDataReady(flushDataReady), .flushAccept(flushAccept),
    .opReq(opReq), .opKind(opKind), .opAddr(opAddr), .opByteEn(opByteEn), .opWrWord(opWrWord),
    .opAccept(opAccept), .rdWord(rdWord), .rdWordValid(rdWordValid), .fillWrite(fillWrite),
    .fillIndex(fillIndex), .fillData(fillData), .busy(busy));
  dcbs_bus_unit dcbs_bus_unit_inst (.clk(clk), .rst_b(rst_b), .link(link), .memWrite(memWrite),
    .memAddr(memAddr), .memWrData(memWrData), .memByteEn(memByteEn), .memRdData(memRdData),
    .memRdAddr(memRdAddr));
  dcbs_link_chk dcbs_link_chk_inst (.clk(clk), .rst_b(rst_b), .busTick(link.busTick), .req(link.req),
    .kind(link.kind), .abort(link.abort), .ack(link.ack), .wrValid(link.wrValid), .rdValid(link.rdValid));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================
  // checks and tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp)
      begin
        bad_count++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
  endtask
  // counts beats at the edge, before that edge's updates land
  always @(posedge clk)
  begin
    if (link.wrValid === 1'b1) wrBeats++;
    if (link.rdValid === 1'b1) rdBeats++;
    if (rdWordValid === 1'b1) rdWords++;
    if (fillWrite === 1'b1)
    begin
      chk(64'(fillIndex), 64'(fillCnt));
      fillCnt++;
    end
  end
  task automatic clear();
    @(negedge clk);
    {wrBeats, rdBeats, fillCnt, rdWords} = '0;
  endtask
  task automatic op(input dcbs_kind_t k, input logic [31:0] a, input logic [7:0] be, input logic [31:0] w);
    int n;
    @(negedge clk);
    opReq = 1'b1;
    opKind = k;
    opAddr = a;
    opByteEn = be;
    opWrWord = w;
    n = 0;
    do @(posedge clk); while (opAccept !== 1'b1 && ++n < 50);
    @(negedge clk);
    opReq = 1'b0;
  endtask
  task automatic flush(input logic [31:0] a);
    int n;
    for (int i = 0; i < 4; i++)
    begin
      @(negedge clk);
      flushDataValid = 1'b1;
      flushData = {a, 32'(i)};
      n = 0;
      do @(posedge clk); while (flushDataReady !== 1'b1 && ++n < 50);
    end
    @(negedge clk);
    flushDataValid = 1'b0;
    flushReq = 1'b1;
    flushAddr = a;
    n = 0;
    do @(posedge clk); while (flushAccept !== 1'b1 && ++n < 100);
    @(negedge clk);
    flushReq = 1'b0;
  endtask
  task automatic end_of_test();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================
  // tests; a run takes about 120 cycles
  initial
  begin
    #50000;
    bad_count++;
    end_of_test();
  end
  initial
  begin
    {coreReset, flushReq, flushDataValid, opReq, flushAddr, opAddr, opWrWord, flushData, opByteEn} = '0;
    opKind = DCBS_LINE_RD;
    rst_b = 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    op(DCBS_WORD_WR, 32'h0000_0100, 8'h0F, 32'hA5A5_1234);
    repeat (3) @(negedge clk);
    chk(64'(memByteEn), 64'h0F);
    chk(64'(memAddr), 64'h100);
    clear();
    op(DCBS_WORD_RD, 32'h0000_0200, 8'hF0, 32'h0);
    op(DCBS_WORD_WR, 32'h0000_0204, 8'h33, 32'h5A5A_0F0F);
    repeat (4) @(negedge clk);
    chk(64'(rdWords), 64'h1);
    chk(64'(rdWord), 64'h200);
    chk(64'(memByteEn), 64'h33);
    clear();
    flush(32'h0000_1000);
    op(DCBS_LINE_RD, 32'h0000_2000, 8'hFF, 32'h0);
    repeat (20) @(negedge clk);
    chk(64'(wrBeats), 64'h4);
    chk(64'(rdBeats), 64'h4);
    chk(64'(fillCnt), 64'h3);
    clear();
    for (int i = 0; i < 3; i++) flush(32'h0000_3000 + 32'(i * 32));
    repeat (30) @(negedge clk);
    chk(64'(wrBeats), 64'hC);
    chk(64'(memAddr), 64'h3058);
    clear();
    flush(32'h0000_5000);
    repeat (4) @(negedge clk);
    opReq = 1'b1;
    opKind = DCBS_LINE_RD;
    coreReset = 1'b1;
    @(negedge clk);
    {opReq, coreReset} = '0;
    repeat (10) @(negedge clk);
    chk(64'(rdBeats), 64'h0);
    chk(64'(fillCnt), 64'h0);
    chk(64'(wrBeats), 64'h4);
    end_of_test();
  end
endmodule

// file: sim/dcbs_link_chk.sv
// concurrent checks on the sequencer link
`timescale 1ns/1ps
module dcbs_link_chk import dcbs_pkg::*; (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       busTick,
  input wire logic       req,
  input wire dcbs_kind_t kind,
  input wire logic       abort,
  input wire logic       ack,
  input wire logic       wrValid,
  input wire logic       rdValid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ==========================================
  // link checks, written for one core cycle per bus cycle
  wire isWr = req && (kind == DCBS_LINE_WR || kind == DCBS_WORD_WR);
  wire isRd = req && (kind == DCBS_LINE_RD || kind == DCBS_WORD_RD);
  wire isWord = req && (kind == DCBS_WORD_RD || kind == DCBS_WORD_WR);
  sequence wrBurst;
    wrValid [*4];
  endsequence
  sequence rdBurst;
    rdValid [*4];
  endsequence
  ack_same_cycle_a: assert property (req |-> ack)
    else $error("request without ack");
  req_on_tick_a: assert property (req |-> busTick)
    else $error("request off a bus edge");
  line_wr_beats_a: assert property (req && kind == DCBS_LINE_WR |-> wrBurst)
    else $error("line write beats short");
  word_wr_data_a: assert property (req && kind == DCBS_WORD_WR |-> wrValid)
    else $error("word write data late");
  write_serial_a: assert property (req && kind == DCBS_LINE_WR |=> !isWr [*3])
    else $error("write pipelined on write");
  line_rd_beats_a: assert property (isRd && !abort && kind == DCBS_LINE_RD |=> rdBurst)
    else $error("line read beats short");
  word_rd_beat_a: assert property (isRd && !abort && kind == DCBS_WORD_RD |=> rdValid ##1 !rdValid)
    else $error("word read beat wrong");
  abort_no_data_a: assert property (isRd && abort && !rdValid |=> !rdValid [*4])
    else $error("data after abort");
  single_gap_a: assert property (isWord |=> !req)
    else $error("request too soon after word");
endmodule
